/* File: dv/bpsf_chassis_sender_bench.sv */
/*
 * bpsf_chassis_sender_bench: drives registers over AHB-Lite and pedal inputs,
 * checks every frame against a queue of expected frames.
 * assumes: package compiled first; short report period.
 */
module bpsf_chassis_sender_bench
    import bpsf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PER = 20;
    logic        clk_sys, arst_n, hsel, hwrite, hready, sensor_fault, tx_ready;
    logic        hreadyout, hresp, irq, lamp, tx_valid, fsoft, cruise_off, mod_diag;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, cnt;
    logic [2:0]  hsize;
    logic [9:0]  pedal_pos, thr_i, thr_m, pos;
    logic [7:0]  bad_cnt;
    bpsf_frame_s tx_frame, f;
    bpsf_frame_s exp_q[$];
    int          err_total, n_tests, n_acc, seed, k;

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    bpsf_chassis_sender #(.PERIOD_CYCLES(PER)) u_bpsf_chassis_sender (
        .clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .pedal_pos(pedal_pos),
        .sensor_fault(sensor_fault), .stop_lamp_switch_output(lamp), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_frame(tx_frame));
    bpsf_engine_model u_bpsf_engine_model (
        .clk_sys(clk_sys), .arst_n(arst_n), .tx_valid(tx_valid), .tx_frame(tx_frame),
        .tx_ready(tx_ready), .invalid_cnt(bad_cnt), .failsoft_seen(fsoft),
        .cruise_off(cruise_off), .moderate_diag(mod_diag));

    task automatic final_report;
        if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string m);
        n_tests++;
        if (seen !== exp) begin
            $display("[FAIL] %0t %s", $time, m);
            err_total++;
        end
    endtask : check

    // one single transfer; entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        hsel   <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            k = 0;
            do begin
                @(posedge clk_sys);
                k++;
            end while (hreadyout !== 1'b1 && k < 40);
            if (hreadyout !== 1'b1) begin
                err_total++;
                final_report();
            end
            htrans <= 2'h0;
            hsel   <= 1'b0;
            hwdata <= d;
        end
        rd = hrdata;
        check(hresp, HRESP_OKAY, "bus response");
    endtask : bus

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
        bus(1'b0, a, 32'h0);
        check(rd, e, m);
    endtask : rd_chk

    task automatic irq_chk(input logic e);
        @(negedge clk_sys);
        check(irq, e, "irq level");
        @(posedge clk_sys);
    endtask : irq_chk

    always @(posedge clk_sys) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (exp_q.size() == 0) check(1, 0, "unexpected frame");
            else check(tx_frame, exp_q.pop_front(), "frame content");
            n_acc++;
        end
    end

    initial begin
        seed = 32'h826F;
        {hsel, hwrite, sensor_fault, arst_n} = 4'h0;
        {haddr, hwdata, htrans, pedal_pos, cnt} = '0;
        hsize = 3'h2;
        hready = 1'b1;
        {err_total, n_tests, n_acc} = '0;
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        for (int a = 0; a <= 32; a += 4) rd_chk(8'(a), 32'h0, "reset value");
        thr_i = 10'($random(seed));
        thr_m = 10'($random(seed));
        bus(1'b1, ADDR_THR_INIT, {22'h0, thr_i});
        bus(1'b1, ADDR_THR_MOD, {22'h0, thr_m});
        rd_chk(ADDR_THR_INIT, {22'h0, thr_i}, "threshold readback");
        bus(1'b1, ADDR_INT_ENABLE, 32'h1);
        // two faulted periods in mid-run; count must resume where it stopped
        for (int i = 0; i < 10; i++) begin
            pos = (i == 1) ? thr_i : (i == 2) ? thr_i + 10'h1 : 10'($random(seed));
            pedal_pos <= pos;
            sensor_fault <= (i == 4 || i == 5);
            f = '{HDR_PRIORITY_BYTE, HDR_TARGET_BYTE, HDR_SOURCE_DEFAULT, HDR_FUNC_FAILSOFT, 8'h00};
            if (i != 4 && i != 5) begin
                f.func_byte = HDR_FUNC_STATUS;
                f.payload = '{2'h0, pos > thr_m, 2'h0 - cnt - {1'b0, pos > thr_i}, cnt, pos > thr_i};
                cnt++;
            end
            exp_q.push_back(f);
            if (i == 0) bus(1'b1, ADDR_CTRL, 32'h3);
            k = 0;
            while (n_acc <= i && k < 200) begin
                @(posedge clk_sys);
                k++;
            end
            if (n_acc <= i) begin
                err_total++;
                final_report();
            end
            check(lamp, (i == 4 || i == 5) ? 1'b1 : pos > thr_i, "lamp level");
        end
        bus(1'b1, ADDR_CTRL, 32'h0);
        irq_chk(1'b1);
        bus(1'b1, ADDR_INT_STATUS, 32'h0);
        rd_chk(ADDR_INT_STATUS, 32'hB, "event status");
        bus(1'b1, ADDR_INT_ENABLE, 32'h0);
        irq_chk(1'b0);
        bus(1'b1, ADDR_INT_ENABLE, 32'hF);
        irq_chk(1'b1);
        bus(1'b1, ADDR_INT_CLEAR, 32'hF);
        irq_chk(1'b0);
        rd_chk(ADDR_INT_STATUS, 32'h0, "status cleared");
        rd_chk(ADDR_TX_COUNT, 32'hA, "frames sent");
        repeat (3 * PER) @(posedge clk_sys);
        check(n_acc, 10, "frame total");
        check(bad_cnt, 8'h00, "receiver rejects");
        check(fsoft, 1'b1, "failsoft received");
        final_report();
    end
endmodule : bpsf_chassis_sender_bench

/* File: dv/bpsf_engine_model.sv */
/*
 * bpsf_engine_model: behavioural engine-side receiver of pedal status frames.
 * assumes: frames offered on a valid/ready handshake; ready stalls at random.
 */
module bpsf_engine_model
    import bpsf_pkg::*;
#(
    parameter int MAX_BAD = 3,
    parameter int TIMEOUT = 1000
) (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        tx_valid,
    input  wire bpsf_frame_s tx_frame,
    output logic             tx_ready,
    output logic [7:0]       invalid_cnt,
    output logic             failsoft_seen,
    output logic             cruise_off,
    output logic             moderate_diag
);
    timeunit 1ns;
    timeprecision 1ps;
    int         seed = 32'h826F;
    int         silent;
    logic       have;
    logic [1:0] last, ref_prot;
    bpsf_payload_s p;
    assign p        = tx_frame.payload;
    assign ref_prot = 2'(2'h0 - p.count - {1'b0, p.initial_travel});
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_ready      <= 1'b0;
            invalid_cnt   <= 8'h00;
            failsoft_seen <= 1'b0;
            cruise_off    <= 1'b0;
            moderate_diag <= 1'b0;
            have          <= 1'b0;
            last          <= 2'h0;
            silent        <= 0;
        end else begin
            // stalls stay short so a held frame never spans a whole period
            tx_ready <= ($random(seed) % 4) != 0;
            silent   <= silent + 1;
            if (silent > TIMEOUT) cruise_off <= 1'b1;
            if (invalid_cnt >= 8'(MAX_BAD)) cruise_off <= 1'b1;
            if (tx_valid && tx_ready && !tx_frame.priority_byte[4]) begin
                silent <= 0;
                if (tx_frame.func_byte == HDR_FUNC_FAILSOFT) begin
                    failsoft_seen <= 1'b1;
                end else if (tx_frame.func_byte == HDR_FUNC_STATUS) begin
                    if (p.protection != ref_prot || (have && p.count != 2'(last + 2'h1))) begin
                        invalid_cnt <= invalid_cnt + 8'h01;
                    end else begin
                        have          <= 1'b1;
                        last          <= p.count;
                        moderate_diag <= p.moderate;
                    end
                end
            end
        end
    end
endmodule : bpsf_engine_model

/* File: dv/bpsf_sender_monitor.sv */
/*
 * bpsf_sender_monitor: assertions on the sender's network-side ports and its stop lamp output.
 * assumes: bound into the sender; enable never rises twice.
 */
module bpsf_sender_monitor
    import bpsf_pkg::*;
#(
    parameter int         PERIOD_CYCLES = 20,
    parameter logic [7:0] SOURCE_BYTE   = 8'h5C
) (
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire bpsf_frame_s tx_frame,
    input wire logic        stop_lamp_switch_output
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic       seen_reg, seen_next, vld_reg, vld_next, rise_reg, rise_next, norm, acc;
    logic [1:0] last_reg, last_next;
    int         gap_reg, gap_next;
    assign norm = tx_frame.func_byte == HDR_FUNC_STATUS;
    assign acc  = tx_valid && tx_ready && norm;
    // gap saturates so a long idle cannot wrap into a false match
    always_comb begin
        seen_next = acc ? 1'b1 : seen_reg;
        last_next = acc ? tx_frame.payload.count : last_reg;
        vld_next  = tx_valid;
        rise_next = rise_reg;
        gap_next  = (gap_reg < 1000) ? gap_reg + 1 : gap_reg;
        if (tx_valid && !vld_reg) begin
            gap_next  = 0;
            rise_next = 1'b1;
        end
    end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            seen_reg <= 1'b0;
            last_reg <= 2'h0;
            vld_reg  <= 1'b0;
            rise_reg <= 1'b0;
            gap_reg  <= 0;
        end else begin
            seen_reg <= seen_next;
            last_reg <= last_next;
            vld_reg  <= vld_next;
            rise_reg <= rise_next;
            gap_reg  <= gap_next;
        end
    end
    hdr_fixed_a: assert property (tx_valid |-> tx_frame.priority_byte == HDR_PRIORITY_BYTE
        && tx_frame.target_byte == HDR_TARGET_BYTE && tx_frame.source_byte == SOURCE_BYTE)
        else $error("header bytes wrong");
    func_code_a: assert property (tx_valid |-> norm || tx_frame.func_byte == HDR_FUNC_FAILSOFT)
        else $error("function byte wrong");
    fs_payload_a: assert property (tx_valid && !norm |-> tx_frame.payload == 8'h00)
        else $error("failsoft payload not zero");
    spare_zero_a: assert property (tx_valid |-> tx_frame.payload.spare == 2'h0)
        else $error("spare bits set");
    prot_match_a: assert property (tx_valid && norm |-> tx_frame.payload.protection ==
        2'(2'h0 - tx_frame.payload.count - {1'b0, tx_frame.payload.initial_travel}))
        else $error("protection mismatch");
    count_step_a: assert property (acc && seen_reg |-> tx_frame.payload.count == 2'(last_reg + 2'h1))
        else $error("rolling count skipped");
    frame_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
        else $error("frame dropped before accept");
    period_gap_a: assert property (tx_valid && !vld_reg && rise_reg |-> gap_reg == PERIOD_CYCLES - 1)
        else $error("report period wrong");
    lamp_flag_a: assert property ($rose(tx_valid) && norm
        |-> stop_lamp_switch_output == tx_frame.payload.initial_travel)
        else $error("lamp differs from travel flag");
endmodule : bpsf_sender_monitor

bind bpsf_chassis_sender bpsf_sender_monitor #(
    .PERIOD_CYCLES(PERIOD_CYCLES),
    .SOURCE_BYTE(SOURCE_BYTE)
) u_bpsf_sender_monitor (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .tx_valid(tx_valid),
    .tx_ready(tx_ready),
    .tx_frame(tx_frame),
    .stop_lamp_switch_output(stop_lamp_switch_output)
);

/* File: verilog/bpsf_chassis_sender.sv */
/*
 * bpsf_chassis_sender: chassis-side sender of the periodic brake pedal
 * status frame, with AHB-Lite registers and one level interrupt.
 * assumes: pedal position and sensing fault
 * are synchronous to clk_sys;
 * the network side takes frames on valid/ready.
 */
// The AHB-Lite register port and the address map are this design's own decisions.
// Summary of operation
// [R1] normal status report every 100 ms, fixed header
// [R2] failsoft report has own header; payload ignored
// [R3] receiver takes only headers with even upper nibble
// [R4] payload: bit0 initial, bits1-2 count, bits3-4 protection, bit5 moderate
// [R5] count steps by one per status report, 3 wraps to 0
// [R6] protection is minus (flag plus count), two bits
// [R7] receiver checks sequence, recomputes protection
// [R8] receiver flags bad protection or broken sequence
// [R9] receiver goes failsoft after set count of invalid messages
// [R10] receiver acts on a failsoft report
// [R11] receiver disengages cruise after silence timeout
// [R12] initial flag when position exceeds first threshold
// [R13] moderate flag when position exceeds second threshold
// [R14] failsoft report whenever a sensing fault spoils the initial flag
// [R15] failsoft report still sent under lamp fallback
// [R16] receiver passes moderate flag to diagnostics
// [R17] receiver starts at zero, skips sequence check until first message
module bpsf_chassis_sender
    import bpsf_pkg::*;
#(
    parameter int         POS_W         = 10,
    parameter int         PERIOD_CYCLES = REPORT_PERIOD_CYCLES,
    parameter logic [7:0] SOURCE_BYTE   = HDR_SOURCE_DEFAULT
) (
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    // ahb-lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic [31:0]           hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic                  irq,
    // pedal sensing system
    input  wire logic [POS_W-1:0] pedal_pos,
    input  wire logic             sensor_fault,
    output logic                  stop_lamp_switch_output,
    // network side
    output logic                  tx_valid,
    input  wire logic             tx_ready,
    output bpsf_frame_s           tx_frame
);

    // register state
    logic [CTRL_W-1:0] ctrl_reg;
    logic [CTRL_W-1:0] ctrl_next;
    logic [POS_W-1:0]  thr_init_reg;
    logic [POS_W-1:0]  thr_init_next;
    logic [POS_W-1:0]  thr_mod_reg;
    logic [POS_W-1:0]  thr_mod_next;
    logic [EV_W-1:0]   int_status_reg;
    logic [EV_W-1:0]   int_status_next;
    logic [EV_W-1:0]   int_enable_reg;
    logic [EV_W-1:0]   int_enable_next;
    logic [31:0]       hrdata_reg;
    logic [31:0]       hrdata_next;
    logic              wr_pend_reg;
    logic              wr_pend_next;
    logic [7:0]        wr_addr_reg;
    logic [7:0]        wr_addr_next;

    // transmit state
    bpsf_tx_e          tx_state_reg;
    bpsf_tx_e          tx_state_next;
    logic [1:0]        count_reg;
    logic [1:0]        count_next;
    logic [31:0]       tx_count_reg;
    logic [31:0]       tx_count_next;
    logic              fault_q_reg;
    logic              fault_q_next;
    logic              lamp_reg;
    logic              lamp_next;

    logic              addr_phase;
    logic              tick;
    logic              load;
    logic              load_failsoft;
    logic              fault_now;
    logic              init_flag;
    logic              mod_flag;
    logic [EV_W-1:0]   events;
    logic [31:0]       wdata_clr;

    bpsf_period_timer #(
        .PERIOD_CYCLES (PERIOD_CYCLES)
    ) u_timer (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .enable  (ctrl_reg[CTRL_ENABLE_BIT]),
        .tick    (tick)
    );

    bpsf_frame_packer #(
        .SOURCE_BYTE (SOURCE_BYTE)
    ) u_packer (
        .clk_sys        (clk_sys),
        .arst_n         (arst_n),
        .load           (load),
        .failsoft       (load_failsoft),
        .initial_travel (init_flag),
        .moderate       (mod_flag),
        .count          (count_reg),
        .frame          (tx_frame)
    );

    // pedal flags and fault
    assign init_flag = (pedal_pos > thr_init_reg);                       // [R12]
    assign mod_flag  = (pedal_pos > thr_mod_reg);                        // [R13]
    assign fault_now = sensor_fault | ctrl_reg[CTRL_FORCE_BIT];          // [R14]

    assign addr_phase = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

    // transmit sequencing
    always_comb begin
        tx_state_next = tx_state_reg;
        count_next    = count_reg;
        tx_count_next = tx_count_reg;
        load          = 1'b0;
        load_failsoft = 1'b0;
        events        = '0;
        case (tx_state_reg)
            BPSF_IDLE: begin
                if (tick) begin
                    // periodic only: no request or change trigger exists
                    load          = 1'b1;                                // [R1]
                    load_failsoft = fault_now;                           // [R14] [R15]
                    tx_state_next = BPSF_PEND;
                    if (!fault_now) begin
                        count_next = count_reg + 2'h1;                   // [R5]
                    end
                end
            end
            BPSF_PEND: begin
                if (tx_ready) begin
                    tx_state_next = BPSF_IDLE;
                    tx_count_next = tx_count_reg + 32'h1;
                    if (tx_frame.func_byte == HDR_FUNC_FAILSOFT) begin
                        events[EV_FAILSOFT_BIT] = 1'b1;
                    end else begin
                        events[EV_STATUS_BIT] = 1'b1;
                    end
                end
                // a tick while the link still holds the last frame is dropped
                if (tick && !tx_ready) begin
                    events[EV_OVERRUN_BIT] = 1'b1;
                end
            end
            default: begin
                tx_state_next = BPSF_IDLE;
            end
        endcase
        if (!ctrl_reg[CTRL_ENABLE_BIT] && tx_state_reg == BPSF_IDLE) begin
            count_next = 2'h0;
        end
        fault_q_next = fault_now;
        if (fault_now && !fault_q_reg) begin
            events[EV_FAULT_BIT] = 1'b1;
        end
        // lamp falls back to the software level while sensing is faulty
        lamp_next = fault_now ? ctrl_reg[CTRL_FALLBACK_BIT] : init_flag; // [R15]
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_state_reg <= BPSF_IDLE;
            count_reg    <= 2'h0;
            tx_count_reg <= 32'h0;
            fault_q_reg  <= 1'b0;
            lamp_reg     <= 1'b0;
        end else begin
            tx_state_reg <= tx_state_next;
            count_reg    <= count_next;
            tx_count_reg <= tx_count_next;
            fault_q_reg  <= fault_q_next;
            lamp_reg     <= lamp_next;
        end
    end

    // register bus: zero wait state, read data captured in the address phase
    always_comb begin
        ctrl_next       = ctrl_reg;
        thr_init_next   = thr_init_reg;
        thr_mod_next    = thr_mod_reg;
        int_enable_next = int_enable_reg;
        wdata_clr       = 32'h0;
        wr_pend_next    = addr_phase & hwrite;
        wr_addr_next    = addr_phase ? haddr[7:0] : wr_addr_reg;
        hrdata_next     = hrdata_reg;
        if (wr_pend_reg) begin
            if (wr_addr_reg == ADDR_CTRL) begin
                ctrl_next = hwdata[CTRL_W-1:0];
            end else if (wr_addr_reg == ADDR_THR_INIT) begin
                thr_init_next = hwdata[POS_W-1:0];
            end else if (wr_addr_reg == ADDR_THR_MOD) begin
                thr_mod_next = hwdata[POS_W-1:0];
            end else if (wr_addr_reg == ADDR_INT_CLEAR) begin
                wdata_clr = hwdata;
            end else if (wr_addr_reg == ADDR_INT_ENABLE) begin
                int_enable_next = hwdata[EV_W-1:0];
            end
        end
        // set wins over a clear in the same cycle
        int_status_next = (int_status_reg & ~wdata_clr[EV_W-1:0]) | events;
        if (addr_phase && !hwrite) begin
            hrdata_next = 32'h0;
            if (haddr[7:0] == ADDR_CTRL) begin
                hrdata_next[CTRL_W-1:0] = ctrl_reg;
            end else if (haddr[7:0] == ADDR_THR_INIT) begin
                hrdata_next[POS_W-1:0] = thr_init_reg;
            end else if (haddr[7:0] == ADDR_THR_MOD) begin
                hrdata_next[POS_W-1:0] = thr_mod_reg;
            end else if (haddr[7:0] == ADDR_INT_STATUS) begin
                hrdata_next[EV_W-1:0] = int_status_reg;
            end else if (haddr[7:0] == ADDR_INT_ENABLE) begin
                hrdata_next[EV_W-1:0] = int_enable_reg;
            end else if (haddr[7:0] == ADDR_STATE) begin
                hrdata_next[ST_PAYLOAD_LSB +: 8] = tx_frame.payload;
                hrdata_next[ST_COUNT_LSB +: 2]   = count_reg;
                hrdata_next[ST_FAULT_BIT]        = fault_now;
                hrdata_next[ST_PEND_BIT]         = (tx_state_reg == BPSF_PEND);
                hrdata_next[ST_LAMP_BIT]         = lamp_reg;
            end else if (haddr[7:0] == ADDR_TX_COUNT) begin
                hrdata_next = tx_count_reg;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg       <= CTRL_RESET;
            thr_init_reg   <= '0;
            thr_mod_reg    <= '0;
            int_status_reg <= '0;
            int_enable_reg <= '0;
            hrdata_reg     <= 32'h0;
            wr_pend_reg    <= 1'b0;
            wr_addr_reg    <= 8'h0;
        end else begin
            ctrl_reg       <= ctrl_next;
            thr_init_reg   <= thr_init_next;
            thr_mod_reg    <= thr_mod_next;
            int_status_reg <= int_status_next;
            int_enable_reg <= int_enable_next;
            hrdata_reg     <= hrdata_next;
            wr_pend_reg    <= wr_pend_next;
            wr_addr_reg    <= wr_addr_next;
        end
    end

    assign hrdata                  = hrdata_reg;
    assign hreadyout               = 1'b1;
    assign hresp                   = HRESP_OKAY;
    assign irq                     = |(int_status_reg & int_enable_reg);
    assign tx_valid                = (tx_state_reg == BPSF_PEND);
    assign stop_lamp_switch_output = lamp_reg;

endmodule : bpsf_chassis_sender

/* File: verilog/bpsf_frame_packer.sv */
/*
 * bpsf_frame_packer: registers one outgoing frame on a load strobe.
 * assumes: the caller loads only while no earlier frame is still offered.
 */
module bpsf_frame_packer
    import bpsf_pkg::*;
#(
    parameter logic [7:0] SOURCE_BYTE = HDR_SOURCE_DEFAULT
) (
    input  wire logic  clk_sys,
    input  wire logic  arst_n,
    input  wire logic  load,
    input  wire logic  failsoft,
    input  wire logic  initial_travel,
    input  wire logic  moderate,
    input  wire logic [1:0] count,
    output bpsf_frame_s     frame
);

    bpsf_frame_s frame_reg;
    bpsf_frame_s frame_next;

    always_comb begin
        frame_next = frame_reg;
        if (load) begin
            frame_next.priority_byte = HDR_PRIORITY_BYTE;
            frame_next.target_byte   = HDR_TARGET_BYTE;
            frame_next.source_byte   = SOURCE_BYTE;
            if (failsoft) begin
                frame_next.func_byte = HDR_FUNC_FAILSOFT;                // [R2]
                frame_next.payload   = FAILSOFT_PAYLOAD;                 // [R2]
            end else begin
                frame_next.func_byte                  = HDR_FUNC_STATUS; // [R1]
                frame_next.payload.spare              = 2'h0;            // [R4]
                frame_next.payload.moderate           = moderate;        // [R4]
                frame_next.payload.protection         = bpsf_protect(initial_travel, count); // [R6]
                frame_next.payload.count              = count;           // [R4]
                frame_next.payload.initial_travel     = initial_travel;  // [R4]
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            frame_reg <= '0;
        end else begin
            frame_reg <= frame_next;
        end
    end

    assign frame = frame_reg;

endmodule : bpsf_frame_packer

/* File: verilog/bpsf_period_timer.sv */
/*
 * bpsf_period_timer: free counter giving a one-cycle tick every PERIOD_CYCLES.
 * assumes: enable low holds the counter at zero so the first tick is one
 * whole period after enable.
 */
module bpsf_period_timer
    import bpsf_pkg::*;
#(
    parameter int PERIOD_CYCLES = REPORT_PERIOD_CYCLES
) (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic enable,
    output logic      tick
);

    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic        tick_reg;
    logic        tick_next;

    always_comb begin
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (!enable) begin
            cnt_next = 32'h0;
        end else if (cnt_reg == 32'(PERIOD_CYCLES - 1)) begin
            cnt_next  = 32'h0;
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg  <= 32'h0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule : bpsf_period_timer

/* File: verilog/bpsf_pkg.sv */
/*
 * bpsf_pkg: constants, register map, field layouts and carrier types for the
 * brake pedal status framer on the chassis side.
 * assumes: a single 40 MHz system clock and a 32-bit AHB-Lite register bus.
 */
package bpsf_pkg;

    // clock and report timing
    localparam real CLK_FREQ_MHZ        = 40.0;
    localparam real REPORT_PERIOD_MS    = 100.0;
    localparam int  REPORT_PERIOD_CYCLES = int'(REPORT_PERIOD_MS * 1000.0 * CLK_FREQ_MHZ);

    // message header bytes
    localparam logic [7:0] HDR_PRIORITY_BYTE  = 8'h48;
    localparam logic [7:0] HDR_TARGET_BYTE    = 8'h33;
    localparam logic [7:0] HDR_FUNC_STATUS    = 8'h2A;
    localparam logic [7:0] HDR_FUNC_FAILSOFT  = 8'h6A;
    // source address byte: value is arbitrary
    localparam logic [7:0] HDR_SOURCE_DEFAULT = 8'h5C;
    localparam logic [7:0] FAILSOFT_PAYLOAD   = 8'h00;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL       = 8'h00;
    localparam logic [7:0] ADDR_THR_INIT   = 8'h04;
    localparam logic [7:0] ADDR_THR_MOD    = 8'h08;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_INT_CLEAR  = 8'h10;
    localparam logic [7:0] ADDR_INT_ENABLE = 8'h14;
    localparam logic [7:0] ADDR_STATE      = 8'h18;
    localparam logic [7:0] ADDR_TX_COUNT   = 8'h1C;

    // control register fields
    localparam int CTRL_ENABLE_BIT   = 0;
    localparam int CTRL_FALLBACK_BIT = 1;
    localparam int CTRL_FORCE_BIT    = 2;
    localparam int CTRL_W            = 3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

    // interrupt status fields
    localparam int EV_STATUS_BIT   = 0;
    localparam int EV_FAILSOFT_BIT = 1;
    localparam int EV_OVERRUN_BIT  = 2;
    localparam int EV_FAULT_BIT    = 3;
    localparam int EV_W            = 4;

    // state register fields
    localparam int ST_PAYLOAD_LSB = 0;
    localparam int ST_COUNT_LSB   = 8;
    localparam int ST_FAULT_BIT   = 10;
    localparam int ST_PEND_BIT    = 11;
    localparam int ST_LAMP_BIT    = 12;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    localparam logic       HRESP_OKAY    = 1'b0;

    typedef struct packed {
        logic [1:0] spare;
        logic       moderate;
        logic [1:0] protection;
        logic [1:0] count;
        logic       initial_travel;
    } bpsf_payload_s;

    typedef struct packed {
        logic [7:0]    priority_byte;
        logic [7:0]    target_byte;
        logic [7:0]    source_byte;
        logic [7:0]    func_byte;
        bpsf_payload_s payload;
    } bpsf_frame_s;

    typedef enum logic [1:0] {
        BPSF_IDLE = 2'b00,
        BPSF_PEND = 2'b01
    } bpsf_tx_e;

    // negation modulo four of flag plus count
    function automatic logic [1:0] bpsf_protect(input logic flag, input logic [1:0] count);
        logic [1:0] sum;
        sum = count + {1'b0, flag};
        return 2'(~sum + 2'h1);
    endfunction : bpsf_protect

endpackage : bpsf_pkg
